// ### logic/sram_host_ctrl.sv
// host controller driving a 16k x 4 static memory with separate data pins
// Summary of operation
// - host holds both selects low at least 10 ns before write ends
// - host holds address 12 ns before write end, zero hold after
// - host keeps write strobe high throughout every read
// - host sets address no later than the later select falls
`timescale 1ns/1ps
module sram_host_ctrl (
  input wire logic clk, // 200 MHz system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic req_valid, // user request strobe
  input wire sram_host_pkg::mem_req_t req, // request fields
  output logic req_ready, // controller idle, may take a request
  output logic [sram_host_pkg::DATA_W-1:0] rdata, // read data
  output logic rdata_valid, // one-cycle pulse with read data
  output logic wr_done, // one-cycle pulse at write end
  input wire logic retention_req, // level: park memory for low supply
  input wire logic supply_ok, // level: supply back at full level
  output logic in_retention, // memory is parked
  output sram_host_pkg::mem_pins_t pins, // pins to the memory
  input wire logic [sram_host_pkg::DATA_W-1:0] mem_dout // memory data outputs
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_READ = 6'h02,
    ST_WRITE = 6'h04,
    ST_WEND = 6'h08,
    ST_RET = 6'h10,
    ST_RECOVER = 6'h20
  } state_t;

  state_t state_q, state_d;
  sram_host_pkg::mem_pins_t pins_q, pins_d;
  logic [sram_host_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d, wdone_q, wdone_d;
  logic [sram_host_pkg::DATA_W-1:0] dout_s1_q, dout_s2_q;
  logic ret_s1_q, ret_s2_q, sup_s1_q, sup_s2_q;
  logic cnt_load, cnt_done;
  logic [sram_host_pkg::CNT_W-1:0] cnt_value;

  // pins from the memory and outside levels cross via two flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dout_s1_q <= '0;
      dout_s2_q <= '0;
      ret_s1_q <= 1'b0;
      ret_s2_q <= 1'b0;
      sup_s1_q <= 1'b0;
      sup_s2_q <= 1'b0;
    end else begin
      dout_s1_q <= mem_dout;
      dout_s2_q <= dout_s1_q;
      ret_s1_q <= retention_req;
      ret_s2_q <= ret_s1_q;
      sup_s1_q <= supply_ok;
      sup_s2_q <= sup_s1_q;
    end
  end

  sram_delay_count u_cnt (
    .clk(clk),
    .resetn(resetn),
    .load(cnt_load),
    .value(cnt_value),
    .done(cnt_done)
  );

  // sequencing of pin phases; every access starts from the idle pin set, holding the last access address except after reset or retention, which zero it
  always_comb begin
    state_d = state_q;
    pins_d = pins_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    wdone_d = 1'b0;
    cnt_load = 1'b0;
    cnt_value = sram_host_pkg::CNT_ZERO;
    unique case (state_q)
      ST_IDLE: begin
        if (ret_s2_q) begin
          pins_d = sram_host_pkg::PINS_IDLE;
          state_d = ST_RET;
        end else if (req_valid) begin
          // address set in the same edge as both selects
          // address held until the access ends
          pins_d.addr = req.addr;
          pins_d.select_a_n = 1'b0;
          pins_d.select_b_n = 1'b0;
          pins_d.din = req.wdata;
          cnt_load = 1'b1;
          if (req.write) begin
            // selects and strobe low together start the write
            // output enable left high so outputs float on either variant
            pins_d.write_n = 1'b0;
            pins_d.out_drive_n = 1'b1;
            cnt_value = sram_host_pkg::CNT_W'(sram_host_pkg::WRITE_PULSE_CYC);
            state_d = ST_WRITE;
          end else begin
            // strobe stays high; output enable low to drive data
            pins_d.write_n = 1'b1;
            pins_d.out_drive_n = 1'b0;
            // two extra cycles for the input synchroniser
            cnt_value = sram_host_pkg::CNT_W'(sram_host_pkg::READ_WAIT_CYC + 2);
            state_d = ST_READ;
          end
        end
      end
      ST_READ: begin
        // wait past select access and output drive access delays
        if (cnt_done) begin
          rdata_d = dout_s2_q;
          rvalid_d = 1'b1;
          pins_d = sram_host_pkg::PINS_IDLE;
          pins_d.addr = pins_q.addr;
          state_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        // strobe and selects held at least 12 ns
        if (cnt_done) begin
          pins_d.write_n = 1'b1;
          state_d = ST_WEND;
        end
      end
      ST_WEND: begin
        // strobe ends first; data and address kept one more cycle
        pins_d = sram_host_pkg::PINS_IDLE;
        pins_d.addr = pins_q.addr;
        wdone_d = 1'b1;
        state_d = ST_IDLE;
      end
      ST_RET: begin
        if (!ret_s2_q && sup_s2_q) begin
          // wait a read cycle after supply returns
          cnt_load = 1'b1;
          cnt_value = sram_host_pkg::CNT_W'(sram_host_pkg::RECOVERY_CYC);
          state_d = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        pins_d = sram_host_pkg::PINS_IDLE;
      end
    endcase
  end

  // register stage; pins, read data and the two pulses come from these flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      pins_q <= sram_host_pkg::PINS_IDLE;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      wdone_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pins_q <= pins_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      wdone_q <= wdone_d;
    end
  end

  logic ready_q, ret_q;
  // ready and retention flags from flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ready_q <= 1'b0;
      ret_q <= 1'b0;
    end else begin
      ready_q <= (state_d == ST_IDLE) && !ret_s2_q;
      ret_q <= (state_d == ST_RET);
    end
  end

  assign pins = pins_q;
  assign rdata = rdata_q;
  assign rdata_valid = rvalid_q;
  assign wr_done = wdone_q;
  assign req_ready = ready_q;
  assign in_retention = ret_q;

  sequence s_write_start;
    $fell(pins_q.write_n);
  endsequence
  sequence s_write_held;
    (!pins_q.write_n && !pins_q.select_a_n && !pins_q.select_b_n)[*3];
  endsequence

  // selects low with strobe for three cycles (15 ns)
  a_write_pulse_len: assert property (@(posedge clk) disable iff (!resetn)
    s_write_start |-> s_write_held) else $error("write pulse too short");
  // address steady through write and one cycle after
  a_write_addr_hold: assert property (@(posedge clk) disable iff (!resetn)
    !pins_q.write_n |=> $stable(pins_q.addr)) else $error("address moved in write");
  a_read_strobe_hi: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == ST_READ) |-> pins_q.write_n) else $error("strobe low in read");
  a_read_addr_stable: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == ST_READ) |=> $stable(pins_q.addr)) else $error("address moved in read");
  a_write_oe_high: assert property (@(posedge clk) disable iff (!resetn)
    !pins_q.write_n |-> pins_q.out_drive_n) else $error("output enable low in write");
  // read answer after the access delay
  a_read_answer: assert property (@(posedge clk) disable iff (!resetn)
    $rose(state_q == ST_READ) |-> (!rvalid_q)[*6] ##1 rvalid_q)
    else $error("read answer timing");
  a_ret_deselect: assert property (@(posedge clk) disable iff (!resetn)
    in_retention |-> pins_q.select_a_n && pins_q.select_b_n) else $error("selected in retention");
  a_recover_wait: assert property (@(posedge clk) disable iff (!resetn)
    $fell(state_q == ST_RET) |-> (state_q == ST_RECOVER)[*3]) else $error("recovery too short");
  a_write_done: assert property (@(posedge clk) disable iff (!resetn)
    $rose(pins_q.write_n) && (state_q == ST_WEND) |=> wdone_q) else $error("no write done");
endmodule

// ### include/sram_host_pkg.sv
// constants and carrier types for the 16k x 4 static memory host controller
package sram_host_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 4;
  localparam int CLK_PERIOD_PS = 5000;
  // timing figures in nanoseconds, fastest grade
  localparam int READ_CYCLE_NS = 12;
  localparam int SELECT_ACCESS_DELAY_NS = 12;
  localparam int OUT_DRIVE_ACCESS_DELAY_NS = 10;
  localparam int SELECT_TO_WRITE_END_NS = 10;
  localparam int ADDR_TO_WRITE_END_NS = 12;
  localparam int ADDR_HOLD_AFTER_WRITE_NS = 0;
  localparam int WRITE_CYCLE_NS = 12;
  // least times round up to whole cycles, never below one
  function automatic int ns_to_cyc_min(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int READ_WAIT_CYC = ns_to_cyc_min(SELECT_ACCESS_DELAY_NS);
  localparam int WRITE_PULSE_CYC = ns_to_cyc_min(ADDR_TO_WRITE_END_NS);
  localparam int RECOVERY_CYC = ns_to_cyc_min(READ_CYCLE_NS);
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  // pins driven to the memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic select_a_n;
    logic select_b_n;
    logic out_drive_n;
    logic write_n;
    logic [DATA_W-1:0] din;
  } mem_pins_t;
  // user request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;
  localparam mem_pins_t PINS_IDLE = '{addr: '0, select_a_n: 1'b1, select_b_n: 1'b1,
    out_drive_n: 1'b1, write_n: 1'b1, din: '0};
endpackage

// ### logic/sram_delay_count.sv
// down counter that measures access phases in clock cycles
`timescale 1ns/1ps
module sram_delay_count (
  input wire logic clk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic load, // start a count
  input wire logic [sram_host_pkg::CNT_W-1:0] value, // cycles to count
  output logic done // count has reached zero and no load this cycle
);
  logic [sram_host_pkg::CNT_W-1:0] cnt_q, cnt_d;

  // next count
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != sram_host_pkg::CNT_ZERO) begin
      cnt_d = cnt_q - sram_host_pkg::CNT_ONE;
    end
  end

  // register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= sram_host_pkg::CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == sram_host_pkg::CNT_ZERO) && !load;
endmodule

// ### dv/sram_model.sv
// behavioural model of the 16k x 4 memory with separate data pins
`timescale 1ns/1ps
module sram_model #(
  parameter bit TRACK = 1'b1 // outputs follow inputs in a write
) (
  input wire sram_host_pkg::mem_pins_t pins, // pins from the host
  // outputs are a pin group of their own
  output logic [sram_host_pkg::DATA_W-1:0] dout // data outputs
);
  logic [sram_host_pkg::DATA_W-1:0] cells [0:16383];
  logic drive;
  int ns_on = 0;
  // drive only when selected with output enable low
  assign drive = !pins.select_a_n && !pins.select_b_n && !pins.out_drive_n
    && (pins.write_n || TRACK);
  // cells change only on a selected strobe, so standby keeps them
  always @(pins) begin
    if (!pins.select_a_n && !pins.select_b_n && !pins.write_n) begin
      cells[pins.addr] = pins.din;
    end
  end
  // valid 12 ns into a drive
  // floating outputs toggle so stale data never passes for a read
  initial dout = 4'h0;
  always #1 begin
    ns_on = drive ? ns_on + 1 : 0;
    if (ns_on >= 12) begin
      dout = pins.write_n ? cells[pins.addr] : pins.din;
    end else begin
      dout = ~dout;
    end
  end
endmodule

// ### dv/tb.sv
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  sram_host_pkg::mem_req_t req = '0;
  logic retention_req = 1'b0;
  logic supply_ok = 1'b1;
  logic req_ready, rdata_valid, wr_done, in_retention;
  logic [3:0] rdata, mem_dout;
  sram_host_pkg::mem_pins_t pins;
  int mismatches = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  sram_host_ctrl uut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid), .wr_done(wr_done),
    .retention_req(retention_req), .supply_ok(supply_ok), .in_retention(in_retention),
    .pins(pins), .mem_dout(mem_dout));
  sram_model #(.TRACK(1'b1)) mem (.pins(pins), .dout(mem_dout));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait at falling edges for ready or parked
  task automatic wait_for(input bit parked, output int n);
    n = 0;
    while ((parked ? in_retention : req_ready) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 40) begin
        chk("wait bound", 32'h0, 32'h1);
        complete_run();
      end
    end
  endtask
  // one access, checking every cycle until its answer
  task automatic access(input logic wr, input logic [13:0] a, input logic [3:0] d);
    int n;
    int lat;
    logic last;
    // answer pulse shows after edge 5 (write) or edge 6 (read) past the take
    lat = wr ? 6 : 7;
    wait_for(1'b0, n);
    req_valid = 1'b1;
    req = '{write: wr, addr: a, wdata: d};
    for (int i = 1; i <= lat; i++) begin
      @(negedge clk);
      req_valid = 1'b0;
      last = (i == lat);
      chk("done", {31'h0, last}, {31'h0, wr ? wr_done : rdata_valid});
      chk("other pulse", 32'h0, {31'h0, wr ? rdata_valid : wr_done});
      chk("ready", {31'h0, last}, {31'h0, req_ready});
      chk("selects", {30'h0, last, last}, {30'h0, pins.select_a_n, pins.select_b_n});
      // in a write the strobe is low for the first four cycles after the take; in a read it stays high
      chk("strobe", {31'h0, !wr || i >= 5}, {31'h0, pins.write_n});
      chk("oe", {31'h0, wr || last}, {31'h0, pins.out_drive_n});
      chk("addr", {18'h0, a}, {18'h0, pins.addr});
      if (wr && !last) chk("din", {28'h0, d}, {28'h0, pins.din});
      if (!wr && last) chk("rdata", {28'h0, d}, {28'h0, rdata});
    end
  endtask
  task automatic test_reset();
    chk("idle pins", {6'h0, sram_host_pkg::PINS_IDLE}, {6'h0, pins});
    chk("ready in reset", 32'h0, {31'h0, req_ready});
    $display("test reset done");
  endtask
  // corner addresses, back to back, with an overwrite
  task automatic test_corners();
    access(1'b1, 14'h0000, 4'h5);
    access(1'b1, 14'h3fff, 4'ha);
    access(1'b0, 14'h0000, 4'h5);
    access(1'b0, 14'h3fff, 4'ha);
    access(1'b1, 14'h0000, 4'h3);
    access(1'b0, 14'h0000, 4'h3);
    $display("test corners done");
  endtask
  task automatic test_all_values();
    for (int v = 0; v < 16; v++) access(1'b1, 14'h1555 + 14'(v), 4'(v));
    for (int v = 0; v < 16; v++) access(1'b0, 14'h1555 + 14'(v), 4'(v));
    $display("test all values done");
  endtask
  // park, drop supply, recover, then read back
  task automatic test_retention();
    int n;
    retention_req = 1'b1;
    wait_for(1'b1, n);
    chk("parked selects", 32'h3, {30'h0, pins.select_a_n, pins.select_b_n});
    chk("ready parked", 32'h0, {31'h0, req_ready});
    supply_ok = 1'b0;
    repeat (10) @(negedge clk);
    supply_ok = 1'b1;
    retention_req = 1'b0;
    wait_for(1'b0, n);
    // two sync flops, one edge to leave park, the recovery count, one edge to idle
    chk("recovery", sram_host_pkg::RECOVERY_CYC + 4, n);
    access(1'b0, 14'h3fff, 4'ha);
    $display("test retention done");
  endtask
  initial begin
    repeat (8) @(negedge clk);
    test_reset();
    resetn = 1'b1;
    test_corners();
    test_all_values();
    test_retention();
    complete_run();
  end
endmodule
